// File: afe_pkg.sv
// Shared constants for the front-end register map and its serial link
package afe_pkg;
   // Address space and frame layout
   localparam int ADDR_W = 4;
   localparam int NUM_REGS = 16;
   localparam int CMD_BITS = 8;
   localparam int CTRL_BITS = 16;
   localparam int WIDE_BITS_DEF = 24;
   localparam logic [5:0] CMD_ADDR_DONE = 6'h04;
   localparam logic [5:0] CMD_LAST = 6'h07;
   localparam logic [5:0] DATA_FIRST = 6'h08;
   localparam logic [5:0] CNT_MAX = 6'h3f;
   localparam logic [2:0] CMD_RESET_TAIL = 3'h7;

   // Register indices
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_RESULT = 4'h1;
   localparam logic [3:0] IDX_EXCITE = 4'h2;
   localparam logic [3:0] IDX_AFE = 4'h3;
   localparam logic [3:0] IDX_CLK = 4'h4;
   localparam logic [3:0] IDX_PIO0 = 4'h5;
   localparam logic [3:0] IDX_PIO1 = 4'h6;
   localparam logic [3:0] IDX_OPTION = 4'h7;
   localparam logic [3:0] IDX_GAIN_CORRECTION_1 = 4'h8;
   localparam logic [3:0] IDX_GAIN_CORRECTION_2 = 4'h9;
   localparam logic [3:0] IDX_RSVD_A = 4'ha;
   localparam logic [3:0] IDX_RSVD_B = 4'hb;
   localparam logic [3:0] IDX_OFFS1 = 4'hc;
   localparam logic [3:0] IDX_OFFS2 = 4'hd;
   localparam logic [3:0] IDX_RSVD_E = 4'he;
   localparam logic [3:0] IDX_RSVD_F = 4'hf;

   // Control register field positions
   localparam int NEG_SEL_LSB = 12;
   localparam int POS_SEL_LSB = 8;
   localparam int UPD_CNT_LSB = 6;
   localparam int DRDY_BIT = 5;
   localparam int OVF_BIT = 4;
   localparam int MODE_LSB = 0;

   // Control register reset values
   localparam logic [3:0] NEG_SEL_RST = 4'h4;
   localparam logic [3:0] POS_SEL_RST = 4'h0;
   localparam logic [1:0] UPD_CNT_RST = 2'h0;
   localparam logic DRDY_N_RST = 1'b1;
   localparam logic OVF_RST = 1'b0;

   // Operation modes
   localparam logic [3:0] MODE_IDLE = 4'h0;
   localparam logic [3:0] MODE_SLEEP = 4'h1;
   localparam logic [3:0] MODE_SINGLE = 4'h2;
   localparam logic [3:0] MODE_CONT = 4'h3;
   localparam logic [3:0] MODE_SINGLE_INPUT_SWAP_CHOPPING = 4'h4;
   localparam logic [3:0] MODE_CONT_INPUT_SWAP_CHOPPING = 4'h5;
   localparam logic [3:0] MODE_SINGLE_XCHOP = 4'h6;
   localparam logic [3:0] MODE_CONT_XCHOP = 4'h7;
   localparam logic [3:0] MODE_CAL_OFFS = 4'hc;
   localparam logic [3:0] MODE_CAL_GAIN = 4'hd;
   localparam logic [3:0] MODE_BOOT = 4'hf;
   localparam logic [3:0] MODE_RST = MODE_BOOT;

   // Plain register reset values and access masks
   localparam logic [23:0] PLAIN_RST [NUM_REGS] = '{default: 24'h000000};
   localparam logic [23:0] WO_MASK [NUM_REGS] = '{default: 24'h000000};
   localparam logic [23:0] RC_MASK [NUM_REGS] = '{default: 24'h000000};

   // Boot duration
   localparam int CLK_PERIOD_NS = 50;
   localparam int BOOT_TIME_NS = 1000;
   localparam int BOOT_CYCLES_DEF = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      AFE_ST_BOOT = 2'b01,
      AFE_ST_RUN = 2'b10
   } afe_state_e;
endpackage : afe_pkg

// File: afe_reg_map.sv
// Register map, control/status register and serial slave of the front end
`timescale 1ns/1ps
module afe_reg_map
   import afe_pkg::*;
#(
   parameter int RES_BITS = WIDE_BITS_DEF,
   parameter int BOOT_CYCLES = BOOT_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_in,
   input wire logic conv_valid,
   input wire logic [23:0] conv_data,
   input wire logic conv_overflow,
   input wire logic cal_done,
   output logic serial_out_ready_pin,
   output logic serial_out_ready_pin_oe_n,
   output logic [3:0] negative_input_select,
   output logic [3:0] positive_input_select,
   output logic [3:0] mode_out,
   output logic data_ready_n,
   output logic overflow_flag,
   output logic [1:0] result_update_counter,
   output logic [15:0] excitation_cfg,
   output logic [15:0] front_end_cfg,
   output logic [15:0] clock_cfg,
   output logic [15:0] pin_io_ctrl0,
   output logic [15:0] pin_io_ctrl1,
   output logic [15:0] misc_options,
   output logic [23:0] gain_corr1,
   output logic [23:0] gain_corr2,
   output logic [23:0] offset_corr1,
   output logic [23:0] offset_corr2
);

   generate
      if (RES_BITS != 16 && RES_BITS != 24) begin : g_bad_width
         $error("RES_BITS must be 16 or 24");
      end
      if (BOOT_CYCLES < 1 || BOOT_CYCLES > 65535) begin : g_bad_boot
         $error("BOOT_CYCLES must be 1 to 65535");
      end
   endgenerate

   localparam logic [4:0] WIDE_LEN = 5'(RES_BITS);
   localparam logic [4:0] CTRL_LEN = 5'(CTRL_BITS);
   localparam logic [15:0] BOOT_LAST = 16'(BOOT_CYCLES - 1);

   // Length of the data field for one address
   // per-location length
   function automatic logic [4:0] reg_len(input logic [3:0] a);
      if (a == IDX_CTRL || (a >= IDX_EXCITE && a <= IDX_OPTION)) begin
         return CTRL_LEN;
      end else begin
         return WIDE_LEN;
      end
   endfunction : reg_len

   function automatic logic [23:0] len_mask(input logic [3:0] a);
      logic [23:0] m;
      m = 24'hffffff >> (5'd24 - reg_len(a));
      return m;
   endfunction : len_mask

   // Locations held by the generic storage
   function automatic logic is_plain(input logic [3:0] a);
      return (a >= IDX_EXCITE && a <= IDX_GAIN_CORRECTION_2) || a == IDX_OFFS1 || a == IDX_OFFS2;
   endfunction : is_plain

   // Modes that may be commanded by a write
   function automatic logic mode_legal(input logic [3:0] m);
      return m <= MODE_CONT_XCHOP || m == MODE_CAL_OFFS || m == MODE_CAL_GAIN;
   endfunction : mode_legal

   // ---------------- Link domain ----------------
   logic [5:0] bit_cnt_r;
   logic [23:0] rx_r;
   logic [3:0] addr_r;
   logic rd_r;
   logic wr_ok_r;
   logic [3:0] req_addr_r;
   logic [23:0] wdata_r;
   logic rd_tgl_r;
   logic wr_tgl_r;
   logic srst_tgl_r;
   logic rdy_l1_r;
   logic rdy_l2_r;
   logic sdo_r;
   logic [23:0] hold_r;
   logic drdy_n_r;
   logic [5:0] last_idx;
   logic [5:0] tx_idx;
   logic [2:0] cmd_tail;

   assign last_idx = 6'(CMD_LAST + {1'b0, reg_len(addr_r)});
   assign tx_idx = 6'(last_idx - bit_cnt_r);
   assign cmd_tail = {rx_r[1:0], serial_in};

   // capture on falling edge; frame state cleared while deselected
   always_ff @(negedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt_r <= 6'h00;
         rx_r <= 24'h000000;
         addr_r <= 4'h0;
         rd_r <= 1'b0;
         wr_ok_r <= 1'b0;
      end else begin
         rx_r <= {rx_r[22:0], serial_in};
         if (bit_cnt_r != CNT_MAX) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
         end
         if (bit_cnt_r == CMD_ADDR_DONE) begin
            addr_r <= rx_r[3:0];
            rd_r <= serial_in;
         end
         if (bit_cnt_r == CMD_LAST) begin
            wr_ok_r <= !rd_r && cmd_tail != CMD_RESET_TAIL;
         end
      end
   end

   // Requests handed to the system domain as toggles
   always_ff @(negedge serial_clk or posedge rst) begin
      if (rst) begin
         rd_tgl_r <= 1'b0;
         wr_tgl_r <= 1'b0;
         srst_tgl_r <= 1'b0;
         req_addr_r <= 4'h0;
         wdata_r <= 24'h000000;
      end else if (!chip_select_n) begin
         if (bit_cnt_r == CMD_ADDR_DONE && serial_in) begin
            req_addr_r <= rx_r[3:0];
            rd_tgl_r <= !rd_tgl_r;
         end
         if (bit_cnt_r == CMD_LAST && !rd_r && cmd_tail == CMD_RESET_TAIL) begin
            srst_tgl_r <= !srst_tgl_r;
         end
         if (wr_ok_r && bit_cnt_r == last_idx) begin
            req_addr_r <= addr_r;
            wdata_r <= {rx_r[22:0], serial_in} & len_mask(addr_r);
            wr_tgl_r <= !wr_tgl_r;
         end
      end
   end

   // Ready level brought onto the serial clock
   always_ff @(posedge serial_clk or posedge rst) begin
      if (rst) begin
         rdy_l1_r <= DRDY_N_RST;
         rdy_l2_r <= DRDY_N_RST;
      end else begin
         rdy_l1_r <= drdy_n_r;
         rdy_l2_r <= rdy_l1_r;
      end
   end

   // output changes on rising edge; read data, else the ready level
   always_ff @(posedge serial_clk or posedge chip_select_n) begin
      if (chip_select_n) begin
         sdo_r <= 1'b1;
      end else if (rd_r && bit_cnt_r >= DATA_FIRST && bit_cnt_r <= last_idx) begin
         sdo_r <= hold_r[tx_idx[4:0]];
      end else begin
         sdo_r <= rdy_l2_r;
      end
   end

   assign serial_out_ready_pin = sdo_r;

   // ---------------- System domain ----------------
   logic cs_s1_r;
   logic cs_s2_r;
   logic oe_n_r;
   logic [2:0] rd_s_r;
   logic [2:0] wr_s_r;
   logic [2:0] sr_s_r;
   logic rd_ev;
   logic wr_ev;
   logic soft_rst;
   logic [3:0] neg_sel_r;
   logic [3:0] pos_sel_r;
   logic [1:0] upd_cnt_r;
   logic ovf_r;
   logic [3:0] mode_r;
   logic [23:0] result_r;
   logic [15:0] boot_cnt_r;
   afe_state_e st_r;
   logic [23:0] gp_r [NUM_REGS];
   logic ctrl_wr;

   // drive the pin while chip select is low, as seen through three clk_sys flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         oe_n_r <= 1'b1;
      end else begin
         cs_s1_r <= chip_select_n;
         cs_s2_r <= cs_s1_r;
         oe_n_r <= cs_s2_r;
      end
   end

   assign serial_out_ready_pin_oe_n = oe_n_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_s_r <= 3'h0;
         wr_s_r <= 3'h0;
         sr_s_r <= 3'h0;
      end else begin
         rd_s_r <= {rd_s_r[1:0], rd_tgl_r};
         wr_s_r <= {wr_s_r[1:0], wr_tgl_r};
         sr_s_r <= {sr_s_r[1:0], srst_tgl_r};
      end
   end

   assign rd_ev = rd_s_r[1] ^ rd_s_r[2];
   assign wr_ev = wr_s_r[1] ^ wr_s_r[2];
   // power-on and serial reset act alike
   assign soft_rst = rst || (sr_s_r[1] ^ sr_s_r[2]);
   assign ctrl_wr = wr_ev && req_addr_r == IDX_CTRL;

   // Read value of one location
   function automatic logic [23:0] read_val(input logic [3:0] a);
      logic [23:0] v;
      v = 24'h000000;
      case (a)
         IDX_CTRL: begin
            v[NEG_SEL_LSB +: 4] = neg_sel_r;
            v[POS_SEL_LSB +: 4] = pos_sel_r;
            v[UPD_CNT_LSB +: 2] = upd_cnt_r;
            v[DRDY_BIT] = drdy_n_r;
            v[OVF_BIT] = ovf_r;
            v[MODE_LSB +: 4] = mode_r;
         end
         IDX_RESULT: v = result_r;
         default: begin
            if (is_plain(a)) begin
               v = gp_r[a];
            end
         end
      endcase
      return v & ~WO_MASK[a] & len_mask(a);
   endfunction : read_val

   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         hold_r <= 24'h000000;
      end else if (rd_ev) begin
         hold_r <= read_val(req_addr_r);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         neg_sel_r <= NEG_SEL_RST;
         pos_sel_r <= POS_SEL_RST;
      end else if (ctrl_wr) begin
         neg_sel_r <= wdata_r[NEG_SEL_LSB +: 4];
         pos_sel_r <= wdata_r[POS_SEL_LSB +: 4];
      end
   end

   // Result register with its counter and flags
   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         result_r <= 24'h000000;
         upd_cnt_r <= UPD_CNT_RST;
         drdy_n_r <= DRDY_N_RST;
         ovf_r <= OVF_RST;
      end else if (conv_valid) begin
         // two's complement code kept as delivered
         result_r <= conv_data & len_mask(IDX_RESULT);
         upd_cnt_r <= upd_cnt_r + 2'h1;
         drdy_n_r <= 1'b0;
         ovf_r <= ovf_r | conv_overflow;
         // read clear only without new result
      end else if (rd_ev && req_addr_r == IDX_RESULT) begin
         // result read returns ready to one
         drdy_n_r <= 1'b1;
         ovf_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (soft_rst) begin
         st_r <= AFE_ST_BOOT;
         mode_r <= MODE_RST;
         boot_cnt_r <= 16'h0000;
      end else begin
         case (st_r)
            AFE_ST_BOOT: begin
               if (boot_cnt_r == BOOT_LAST) begin
                  st_r <= AFE_ST_RUN;
                  mode_r <= MODE_IDLE;
               end else begin
                  boot_cnt_r <= boot_cnt_r + 16'h0001;
               end
            end
            AFE_ST_RUN: begin
               // unused and boot codes are not accepted
               if (ctrl_wr && mode_legal(wdata_r[MODE_LSB +: 4])) begin
                  mode_r <= wdata_r[MODE_LSB +: 4];
               end else if (conv_valid && (mode_r == MODE_SINGLE || mode_r == MODE_SINGLE_INPUT_SWAP_CHOPPING ||
                                           mode_r == MODE_SINGLE_XCHOP)) begin
                  mode_r <= MODE_IDLE;
               end else if (cal_done && (mode_r == MODE_CAL_OFFS || mode_r == MODE_CAL_GAIN)) begin
                  mode_r <= MODE_IDLE;
               end
            end
            default: begin
               st_r <= AFE_ST_BOOT;
               mode_r <= MODE_RST;
            end
         endcase
      end
   end

   // Generic configuration and correction registers
   generate
      for (genvar i = 0; i < NUM_REGS; i++) begin : g_plain
         if (is_plain(4'(i))) begin : g_store
            always_ff @(posedge clk_sys) begin
               if (soft_rst) begin
                  gp_r[i] <= PLAIN_RST[i] & len_mask(4'(i));
               end else if (wr_ev && req_addr_r == 4'(i)) begin
                  // clear-on-one bits keep value on zero
                  gp_r[i] <= ((wdata_r & ~RC_MASK[i]) | (gp_r[i] & ~wdata_r & RC_MASK[i])) & len_mask(4'(i));
               end
            end
         end else begin : g_none
            always_ff @(posedge clk_sys) begin
               gp_r[i] <= 24'h000000;
            end
         end
      end
   endgenerate

   assign negative_input_select = neg_sel_r;
   assign positive_input_select = pos_sel_r;
   assign mode_out = mode_r;
   assign data_ready_n = drdy_n_r;
   assign overflow_flag = ovf_r;
   assign result_update_counter = upd_cnt_r;
   assign excitation_cfg = gp_r[IDX_EXCITE][15:0];
   assign front_end_cfg = gp_r[IDX_AFE][15:0];
   assign clock_cfg = gp_r[IDX_CLK][15:0];
   assign pin_io_ctrl0 = gp_r[IDX_PIO0][15:0];
   assign pin_io_ctrl1 = gp_r[IDX_PIO1][15:0];
   assign misc_options = gp_r[IDX_OPTION][15:0];
   assign gain_corr1 = gp_r[IDX_GAIN_CORRECTION_1];
   assign gain_corr2 = gp_r[IDX_GAIN_CORRECTION_2];
   assign offset_corr1 = gp_r[IDX_OFFS1];
   assign offset_corr2 = gp_r[IDX_OFFS2];
endmodule : afe_reg_map

// File: afe_reg_map_monitor.sv
// Port-level assertions for the front-end register map
`timescale 1ns/1ps
module afe_reg_map_monitor
   import afe_pkg::*;
#(
   parameter int BOOT_CYCLES = BOOT_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic conv_valid,
   input wire logic conv_overflow,
   input wire logic serial_out_ready_pin,
   input wire logic serial_out_ready_pin_oe_n,
   input wire logic [3:0] negative_input_select,
   input wire logic [3:0] positive_input_select,
   input wire logic [3:0] mode_out,
   input wire logic data_ready_n,
   input wire logic overflow_flag,
   input wire logic [1:0] result_update_counter
);
   localparam int BOOT_HI = BOOT_CYCLES + 4;
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   chk_count_step: assert property (conv_valid |=> result_update_counter == $past(result_update_counter) + 2'h1)
      else $error("counter did not step");
   chk_ready_low: assert property (conv_valid |=> !data_ready_n)
      else $error("ready flag not low");
   chk_ready_cause: assert property ($fell(data_ready_n) |-> $past(conv_valid))
      else $error("ready flag fell alone");
   chk_ovf_set: assert property (conv_valid && conv_overflow |=> overflow_flag)
      else $error("overflow not set");
   chk_ovf_cause: assert property ($rose(overflow_flag) |-> $past(conv_valid && conv_overflow))
      else $error("overflow rose alone");
   chk_reset_load: assert property (disable iff (1'b0) rst |=> negative_input_select == NEG_SEL_RST
      && positive_input_select == POS_SEL_RST && result_update_counter == 2'h0 && data_ready_n
      && !overflow_flag && mode_out == MODE_BOOT)
      else $error("bad reset values");
   chk_boot_exit: assert property ($fell(rst) |-> ##[1:BOOT_HI] mode_out == MODE_IDLE)
      else $error("boot not left");
   chk_pin_release: assert property (chip_select_n [*5] |-> serial_out_ready_pin_oe_n && serial_out_ready_pin)
      else $error("pin not released");
   chk_pin_drive: assert property ($fell(chip_select_n) |-> ##[1:5] !serial_out_ready_pin_oe_n)
      else $error("pin not driven");
   chk_single_done: assert property (mode_out == MODE_SINGLE && conv_valid |-> ##[1:2] mode_out == MODE_IDLE)
      else $error("single mode stuck");
endmodule : afe_reg_map_monitor

bind afe_reg_map afe_reg_map_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) u_mon (
   .clk_sys(clk_sys), .rst(rst), .chip_select_n(chip_select_n), .conv_valid(conv_valid),
   .conv_overflow(conv_overflow), .serial_out_ready_pin(serial_out_ready_pin),
   .serial_out_ready_pin_oe_n(serial_out_ready_pin_oe_n), .negative_input_select(negative_input_select),
   .positive_input_select(positive_input_select), .mode_out(mode_out), .data_ready_n(data_ready_n),
   .overflow_flag(overflow_flag), .result_update_counter(result_update_counter)
);

// File: afe_host_model.sv
// Host serial master model for the register map link
`timescale 1ns/1ps
module afe_host_model (
   output logic serial_clk,
   output logic chip_select_n,
   output logic serial_in,
   input wire logic serial_out_ready_pin,
   input wire logic serial_out_ready_pin_oe_n
);
   logic last_r;
   initial begin
      serial_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
      last_r = 1'b0;
   end
   // Command byte then nbits of data, MSB first; returns data bits seen
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nbits, output logic [23:0] rd);
      logic [31:0] sh;
      logic v;
      sh = {cmd, wd << (24 - nbits)};
      rd = 24'h000000;
      #37;
      chip_select_n = 1'b0;
      #62.5;
      for (int i = 0; i < 8 + nbits; i++) begin
         serial_clk = 1'b1;
         serial_in = sh[31 - i];
         #62.5;
         serial_clk = 1'b0;
         // Released pin has no pull, so it is not trusted
         v = serial_out_ready_pin_oe_n ? ~last_r : serial_out_ready_pin;
         last_r = v;
         if (i >= 8) begin
            rd = {rd[22:0], v};
         end
         #62.5;
      end
      chip_select_n = 1'b1;
      serial_in = ~serial_in;
      #500;
   endtask : xfer
endmodule : afe_host_model

// File: afe_spi_register_map_ctrl_tb.sv
// Self-checking bench for the front-end register map
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module afe_spi_register_map_ctrl_tb;
   import afe_pkg::*;
   logic clk_sys, rst, conv_valid, conv_overflow, cal_done, serial_clk, chip_select_n, serial_in, pin, oe_n;
   logic [23:0] conv_data;
   logic [3:0] neg_sel, pos_sel, mode_out;
   logic data_ready_n, overflow_flag;
   logic [1:0] result_update_counter;
   logic [23:0] mdl [16];
   logic [15:0] cfg_s [2:7];
   logic [23:0] cfg_w [4];
   int err_count, total_checks, cyc, sel_m, mode_m, cnt_m, rdy_m, ovf_m;
   logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'hc, 4'hd, 4'h2, 4'h4, 4'h6};
   afe_reg_map #(.RES_BITS(24), .BOOT_CYCLES(1)) DUT (
      .clk_sys(clk_sys), .rst(rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
      .serial_in(serial_in), .conv_valid(conv_valid), .conv_data(conv_data), .conv_overflow(conv_overflow),
      .cal_done(cal_done), .serial_out_ready_pin(pin), .serial_out_ready_pin_oe_n(oe_n),
      .negative_input_select(neg_sel), .positive_input_select(pos_sel), .mode_out(mode_out),
      .data_ready_n(data_ready_n), .overflow_flag(overflow_flag), .result_update_counter(result_update_counter),
      .excitation_cfg(cfg_s[2]), .front_end_cfg(cfg_s[3]), .clock_cfg(cfg_s[4]), .pin_io_ctrl0(cfg_s[5]),
      .pin_io_ctrl1(cfg_s[6]), .misc_options(cfg_s[7]), .gain_corr1(cfg_w[0]), .gain_corr2(cfg_w[1]),
      .offset_corr1(cfg_w[2]), .offset_corr2(cfg_w[3])
   );
   afe_host_model host (
      .serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
      .serial_out_ready_pin(pin), .serial_out_ready_pin_oe_n(oe_n)
   );
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   function automatic int len(input int a);
      return (a == 0 || (a > 1 && a < 8)) ? 16 : 24;
   endfunction : len
   function automatic logic [23:0] ctrl_exp();
      return {8'h00, sel_m[7:0], cnt_m[1:0], rdy_m[0], ovf_m[0], mode_m[3:0]};
   endfunction : ctrl_exp
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic mdl_reset();
      foreach (mdl[i]) mdl[i] = 24'h000000;
      sel_m = 8'h40;
      mode_m = 0;
      cnt_m = 0;
      rdy_m = 1;
      ovf_m = 0;
   endtask : mdl_reset
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      logic [23:0] q;
      host.xfer({a, 4'h0}, d, len(a), q);
      if (a == 4'h0) begin
         sel_m = d[15:8];
         mode_m = d[3:0];
      end else if (!(a inside {4'h1, 4'ha, 4'hb, 4'he, 4'hf})) begin
         mdl[a] = (len(a) == 16) ? {8'h00, d[15:0]} : d;
      end
   endtask : wr
   task automatic rdchk(input logic [3:0] a);
      logic [23:0] q;
      logic [23:0] e;
      logic [15:0] pv;
      host.xfer({a, 4'h8}, 24'h000000, len(a), q);
      e = (a == 4'h0) ? ctrl_exp() : mdl[a];
      pv = {neg_sel, pos_sel, result_update_counter, data_ready_n, overflow_flag, mode_out};
      `CHK(q, e)
      if (a == 4'h0) begin
         `CHK(pv, e[15:0])
      end
      if (a inside {[4'h2:4'h7]}) begin
         `CHK(cfg_s[a], mdl[a][15:0])
      end
      if (a inside {4'h8, 4'h9, 4'hc, 4'hd}) begin
         `CHK(cfg_w[{a[2], a[0]}], mdl[a])
      end
      if (a == 4'h1) begin
         rdy_m = 1;
         ovf_m = 0;
      end
   endtask : rdchk
   task automatic conv(input logic ov);
      @(negedge clk_sys);
      conv_data = 24'($urandom);
      conv_overflow = ov;
      conv_valid = 1'b1;
      @(negedge clk_sys);
      conv_valid = 1'b0;
      mdl[1] = conv_data;
      cnt_m = (cnt_m + 1) % 4;
      rdy_m = 0;
      ovf_m = ovf_m | ov;
      if (mode_m inside {2, 4, 6}) begin
         mode_m = 0;
      end
   endtask : conv
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      logic [23:0] d;
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      {rst, conv_valid, conv_overflow, cal_done, conv_data} = {1'b1, 27'h0};
      d = 24'($urandom(32'h59e0));
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      mdl_reset();
      repeat (10) @(negedge clk_sys);
      rdchk(4'h0);
      foreach (modes[i]) begin
         d = 24'($urandom);
         d[3:0] = modes[i];
         wr(4'h0, d);
         rdchk(4'h0);
         if (modes[i] inside {4'h2, 4'h4, 4'h6}) begin
            conv(1'b0);
            rdchk(4'h0);
         end
         if (modes[i] inside {4'hc, 4'hd}) begin
            @(negedge clk_sys);
            cal_done = 1'b1;
            @(negedge clk_sys);
            cal_done = 1'b0;
            mode_m = 0;
            rdchk(4'h0);
         end
      end
      repeat (3) begin
         conv(1'b0);
         conv(1'b1);
         rdchk(4'h0);
         rdchk(4'h1);
         rdchk(4'h0);
      end
      for (int a = 1; a < 16; a++) begin
         d = 24'($urandom);
         wr(a[3:0], d);
      end
      for (int a = 1; a < 16; a++) begin
         rdchk(a[3:0]);
      end
      host.xfer(8'h07, 24'h000000, 0, d);
      mdl_reset();
      repeat (10) @(negedge clk_sys);
      for (int a = 0; a < 16; a++) begin
         if (a != 1) begin
            rdchk(a[3:0]);
         end
      end
      give_verdict();
   end
endmodule : afe_spi_register_map_ctrl_tb
